// ---- hdl/bsfx_exec.sv ----
// Top of the bit, shift and flag execution unit.
// Assumes one request pulse at a time and waits for done before the next.
`timescale 1ns/1ps
`default_nettype none
`include "bsfx_defs.svh"
module bsfx_exec (
    input  wire logic              clk_sys,     // Core clock, 40 MHz
    input  wire logic              rst_n,       // Synchronous reset, low
    input  wire logic              req_valid,   // One-cycle request pulse
    input  wire bsfx_pkg::bsfx_req_t req,       // Decoded instruction
    input  wire logic              nvm_busy,    // Memory controller still busy
    output var bsfx_pkg::bsfx_out_t out,        // Registered results
    output logic                   busy         // Instruction in progress
);
    import bsfx_pkg::*;

    typedef struct packed {
        bsfx_state_t state;
        bsfx_req_t   req;
        logic [1:0]  cnt;
        bsfx_out_t   out;
        logic        busy;
    } bsfx_st_t;

    bsfx_st_t   st_r;
    bsfx_st_t   st_nxt;
    logic [7:0] sh_res;
    logic [7:0] sh_status_flags_reg;
    logic [2:0] flag_sel;

    bsfx_shift u_shift (
        .op       (req.op),
        .rd       (req.rd),
        .status_flags_reg_in  (st_r.out.status_flags_reg),
        .res      (sh_res),
        .status_flags_reg_out (sh_status_flags_reg)
    );

    assign flag_sel = req.bit_sel;

    always_comb begin
        st_nxt = st_r;
        st_nxt.out.done = 1'b0;
        st_nxt.out.result_we = 1'b0;
        st_nxt.out.io_we = 1'b0;
        st_nxt.out.debug_break = 1'b0;
        st_nxt.out.sleep_req = 1'b0;
        st_nxt.out.wdog_restart = 1'b0;
        case (st_r.state)
            BSFX_ST_IDLE: begin
                if (req_valid) begin
                    st_nxt.req = req;
                    case (req.op)
                        BSFX_OP_LSL, BSFX_OP_LSR, BSFX_OP_ROL, BSFX_OP_ROR,
                        BSFX_OP_ASR, BSFX_OP_SWAP: begin
                            st_nxt.out.result = sh_res;
                            st_nxt.out.result_we = 1'b1;
                            st_nxt.out.status_flags_reg = sh_status_flags_reg;
                            st_nxt.out.done = 1'b1;
                        end
                        BSFX_OP_IOSET, BSFX_OP_IOCLR: begin
                            st_nxt.out.io_wdata = req.io_rdata;
                            st_nxt.out.io_wdata[req.bit_sel] =
                                (req.op == BSFX_OP_IOSET);
                            st_nxt.state = BSFX_ST_DONE;
                            st_nxt.busy = 1'b1;
                        end
                        BSFX_OP_BST: begin
                            st_nxt.out.status_flags_reg[`BSFX_FLAG_T] = req.rd[req.bit_sel];
                            st_nxt.out.done = 1'b1;
                        end
                        BSFX_OP_BLD: begin
                            st_nxt.out.result = req.rd;
                            st_nxt.out.result[req.bit_sel] =
                                st_r.out.status_flags_reg[`BSFX_FLAG_T];
                            st_nxt.out.result_we = 1'b1;
                            st_nxt.out.done = 1'b1;
                        end
                        BSFX_OP_FSET, BSFX_OP_FCLR: begin
                            st_nxt.out.status_flags_reg[flag_sel] = (req.op == BSFX_OP_FSET);
                            st_nxt.out.done = 1'b1;
                        end
                        BSFX_OP_BRK: begin
                            st_nxt.out.debug_break = 1'b1;
                            st_nxt.out.done = 1'b1;
                        end
                        BSFX_OP_SLP: begin
                            st_nxt.out.sleep_req = 1'b1;
                            st_nxt.out.done = 1'b1;
                        end
                        BSFX_OP_WDR: begin
                            st_nxt.out.wdog_restart = 1'b1;
                            st_nxt.out.done = 1'b1;
                        end
                        BSFX_OP_STORE, BSFX_OP_LOAD: begin
                            st_nxt.cnt = req.base_cycles;
                            if (req.op == BSFX_OP_STORE &&
                                req.mem_addr < `BSFX_LOW_IO_LIM) begin
                                st_nxt.cnt = req.base_cycles + 2'h1;
                            end
                            st_nxt.state = BSFX_ST_BASE;
                            st_nxt.busy = 1'b1;
                        end
                        default: st_nxt.out.done = 1'b1;
                    endcase
                end
            end
            BSFX_ST_BASE: begin
                if (st_r.cnt > 2'h1) begin
                    st_nxt.cnt = st_r.cnt - 2'h1;
                end else if (st_r.req.mem_nvm) begin
                    st_nxt.cnt = `BSFX_NVM_MIN_WAIT;
                    st_nxt.state = BSFX_ST_NVM;
                end else begin
                    st_nxt.out.done = 1'b1;
                    st_nxt.busy = 1'b0;
                    st_nxt.state = BSFX_ST_IDLE;
                end
            end
            BSFX_ST_NVM: begin
                // Minimum extra wait is counted down here, then held on busy
                if (st_r.cnt > 2'h1) begin
                    st_nxt.cnt = st_r.cnt - 2'h1;
                end else if (!nvm_busy) begin
                    st_nxt.out.done = 1'b1;
                    st_nxt.busy = 1'b0;
                    st_nxt.state = BSFX_ST_IDLE;
                end
            end
            BSFX_ST_DONE: begin
                st_nxt.out.io_we = 1'b1;
                st_nxt.out.done = 1'b1;
                st_nxt.busy = 1'b0;
                st_nxt.state = BSFX_ST_IDLE;
            end
            default: st_nxt.state = BSFX_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.state <= BSFX_ST_IDLE;
            st_r.out.status_flags_reg <= `BSFX_STATUS_FLAGS_REG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out = st_r.out;
    assign busy = st_r.busy;
endmodule : bsfx_exec
`default_nettype wire

// ---- hdl/bsfx_defs.svh ----
// Constants of the bit, shift and flag execution unit.
// Assumes inclusion by bare name from the design modules.
`ifndef BSFX_DEFS_SVH
`define BSFX_DEFS_SVH
`define BSFX_FLAG_C       3'd0
`define BSFX_FLAG_Z       3'd1
`define BSFX_FLAG_N       3'd2
`define BSFX_FLAG_V       3'd3
`define BSFX_FLAG_S       3'd4
`define BSFX_FLAG_H       3'd5
`define BSFX_FLAG_T       3'd6
`define BSFX_FLAG_I       3'd7
`define BSFX_STATUS_FLAGS_REG_RST     8'h00
`define BSFX_LOW_IO_LIM   8'h40
`define BSFX_NVM_MIN_WAIT 2'h1
`endif

// ---- hdl/bsfx_pkg.sv ----
// Types of the bit, shift and flag execution unit.
// Assumes the constants header is on the include path.
package bsfx_pkg;
    typedef enum logic [4:0] {
        BSFX_OP_NONE = 5'h00, BSFX_OP_LSL = 5'h01, BSFX_OP_LSR = 5'h02,
        BSFX_OP_ROL  = 5'h03, BSFX_OP_ROR = 5'h04, BSFX_OP_ASR = 5'h05,
        BSFX_OP_SWAP = 5'h06, BSFX_OP_IOSET = 5'h07, BSFX_OP_IOCLR = 5'h08,
        BSFX_OP_BST  = 5'h09, BSFX_OP_BLD = 5'h0a, BSFX_OP_FSET = 5'h0b,
        BSFX_OP_FCLR = 5'h0c, BSFX_OP_BRK = 5'h0d, BSFX_OP_SLP = 5'h0e,
        BSFX_OP_WDR  = 5'h0f, BSFX_OP_NOP = 5'h10, BSFX_OP_STORE = 5'h11,
        BSFX_OP_LOAD = 5'h12
    } bsfx_op_t;

    typedef struct packed {
        bsfx_op_t   op;
        logic [7:0] rd;
        logic [2:0] bit_sel;
        logic [7:0] io_addr;
        logic [7:0] io_rdata;
        logic [7:0] mem_addr;
        logic       mem_nvm;
        logic [1:0] base_cycles;
    } bsfx_req_t;

    typedef struct packed {
        logic [7:0] result;
        logic       result_we;
        logic [7:0] io_wdata;
        logic       io_we;
        logic [7:0] status_flags_reg;
        logic       done;
        logic       debug_break;
        logic       sleep_req;
        logic       wdog_restart;
    } bsfx_out_t;

    typedef enum logic [3:0] {
        BSFX_ST_IDLE = 4'b0001, BSFX_ST_BASE = 4'b0010,
        BSFX_ST_NVM = 4'b0100, BSFX_ST_DONE = 4'b1000
    } bsfx_state_t;
endpackage : bsfx_pkg

// ---- hdl/bsfx_shift.sv ----
// Combinational shift, rotate and nibble-swap unit with flag results.
// Assumes the caller writes the returned flags back as the whole status byte.
`timescale 1ns/1ps
`default_nettype none
`include "bsfx_defs.svh"
module bsfx_shift (
    input  wire bsfx_pkg::bsfx_op_t op,        // Shift selection
    input  wire logic [7:0]        rd,        // Operand
    input  wire logic [7:0]        status_flags_reg_in,   // Current flags
    output logic [7:0]             res,       // Shifted result
    output logic [7:0]             status_flags_reg_out   // Updated flags
);
    import bsfx_pkg::*;
    logic c_new;
    logic n_new;
    always_comb begin
        res = rd;
        c_new = status_flags_reg_in[`BSFX_FLAG_C];
        case (op)
            BSFX_OP_LSL: begin
                res = {rd[6:0], 1'b0};
                c_new = rd[7];
            end
            BSFX_OP_LSR: begin
                res = {1'b0, rd[7:1]};
                c_new = rd[0];
            end
            BSFX_OP_ROL: begin
                res = {rd[6:0], status_flags_reg_in[`BSFX_FLAG_C]};
                c_new = rd[7];
            end
            BSFX_OP_ROR: begin
                res = {status_flags_reg_in[`BSFX_FLAG_C], rd[7:1]};
                c_new = rd[0];
            end
            BSFX_OP_ASR: begin
                res = {rd[7], rd[7:1]};
                c_new = rd[0];
            end
            BSFX_OP_SWAP: res = {rd[3:0], rd[7:4]};
            default: res = rd;
        endcase
        n_new = res[7];
        status_flags_reg_out = status_flags_reg_in;
        if (op != BSFX_OP_SWAP) begin
            status_flags_reg_out[`BSFX_FLAG_C] = c_new;
            status_flags_reg_out[`BSFX_FLAG_Z] = (res == 8'h00);
            status_flags_reg_out[`BSFX_FLAG_N] = n_new;
            status_flags_reg_out[`BSFX_FLAG_V] = n_new ^ c_new;
            status_flags_reg_out[`BSFX_FLAG_S] = c_new;
            if (op == BSFX_OP_LSL || op == BSFX_OP_ROL) begin
                status_flags_reg_out[`BSFX_FLAG_H] = rd[3];
            end
        end
    end
endmodule : bsfx_shift
`default_nettype wire

// ---- verif/bsfx_exec_assertions.sv ----
// Checker for the bit, shift and flag execution unit.
// Assumes it is bound onto bsfx_exec.
`timescale 1ns/1ps
`default_nettype none
module bsfx_exec_chk (
    input wire logic                clk_sys,   // Clock
    input wire logic                rst_n,     // Reset
    input wire logic                req_valid, // Strobe
    input wire bsfx_pkg::bsfx_req_t req,       // Request
    input wire logic                nvm_busy,  // Wait
    input wire bsfx_pkg::bsfx_out_t out,       // Results
    input wire logic                busy       // Busy
);
    import bsfx_pkg::*;
    logic       tk;
    logic       bit_r;
    logic [7:0] bld_r;
    assign tk = req_valid && !busy;
    // Expected bit copies, one cycle behind
    always_ff @(posedge clk_sys) begin
        bit_r <= req.rd[req.bit_sel];
        bld_r <= (req.rd & ~(8'h01 << req.bit_sel)) | ({7'h00, out.status_flags_reg[6]} << req.bit_sel);
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    one_cycle_done_a: assert property (
        tk && req.op inside {[5'h01:5'h06], [5'h09:5'h0f]} |=> out.done) else $error("done late");
    io_set_a: assert property (tk && req.op == 5'h07 |=> busy && $stable(out.status_flags_reg) ##1
        out.done && out.io_we && $stable(out.status_flags_reg)
        && out.io_wdata == ($past(req.io_rdata, 2) | (8'h01 << $past(req.bit_sel, 2))))
        else $error("io set wrong");
    io_clr_a: assert property (tk && req.op == 5'h08 |=> busy && $stable(out.status_flags_reg) ##1
        out.done && out.io_we && $stable(out.status_flags_reg)
        && out.io_wdata == ($past(req.io_rdata, 2) & ~(8'h01 << $past(req.bit_sel, 2))))
        else $error("io clear wrong");
    bit_store_a: assert property (tk && req.op == 5'h09 |=> out.status_flags_reg[6] == bit_r
        && out.status_flags_reg[5:0] == $past(out.status_flags_reg[5:0]) && out.status_flags_reg[7] == $past(out.status_flags_reg[7]))
        else $error("bit store wrong");
    bit_load_a: assert property (tk && req.op == 5'h0a |=> out.result_we
        && out.result == bld_r && $stable(out.status_flags_reg)) else $error("bit load wrong");
    flag_set_a: assert property (tk && req.op == 5'h0b |=>
        out.status_flags_reg == ($past(out.status_flags_reg) | (8'h01 << $past(req.bit_sel)))) else $error("flag set");
    flag_clr_a: assert property (tk && req.op == 5'h0c |=>
        out.status_flags_reg == ($past(out.status_flags_reg) & ~(8'h01 << $past(req.bit_sel)))) else $error("flag clr");
    break_pulse_a: assert property (tk && req.op == 5'h0d |=>
        out.debug_break && $stable(out.status_flags_reg) ##1 !out.debug_break) else $error("break");
    sleep_pulse_a: assert property (tk && req.op == 5'h0e |=>
        out.sleep_req && $stable(out.status_flags_reg) ##1 !out.sleep_req) else $error("sleep");
    wdog_pulse_a: assert property (tk && req.op == 5'h0f |=>
        out.wdog_restart && $stable(out.status_flags_reg) ##1 !out.wdog_restart) else $error("wdog");
endmodule : bsfx_exec_chk
bind bsfx_exec bsfx_exec_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req(req), .nvm_busy(nvm_busy), .out(out), .busy(busy));
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the bit, shift and flag execution unit.
// Assumes the package and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bsfx_pkg::*;
    logic      clk_sys = 1'b0;
    logic      rst_n = 1'b0;
    logic      req_valid = 1'b0;
    logic      nvm_busy = 1'b0;
    bsfx_req_t req = '0;
    bsfx_out_t out;
    bsfx_out_t o;
    logic      busy;
    logic [7:0] sr = 8'h00;
    int        error_cnt = 0;
    int        checked = 0;
    int        n;
    int        m;
    always #12.5 clk_sys = ~clk_sys;
    bsfx_exec dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .nvm_busy(nvm_busy), .out(out), .busy(busy));
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    // Pulse one request, count cycles until done
    task automatic go(input logic [4:0] op, input logic [7:0] rd, input logic [2:0] b,
        input int hold);
        @(negedge clk_sys);
        req.op = bsfx_op_t'(op);
        req.rd = rd;
        req.bit_sel = b;
        req_valid = 1'b1;
        nvm_busy = (hold > 0);
        n = 0;
        do begin
            @(negedge clk_sys);
            req_valid = 1'b0;
            n++;
            if (n >= hold) nvm_busy = 1'b0;
        end while (out.done !== 1'b1 && n < 40);
        o = out;
    endtask : go
    function automatic logic [15:0] shx(input logic [4:0] op, input logic [7:0] d,
        input logic [7:0] s);
        logic [7:0] r;
        logic       up;
        up = (op == 5'h01 || op == 5'h03);
        r = up ? {d[6:0], op == 5'h03 && s[0]} : {op == 5'h04 ? s[0] : op == 5'h05 && d[7], d[7:1]};
        s[0] = up ? d[7] : d[0];
        s[1] = (r == 8'h00);
        s[2] = r[7];
        s[3] = r[7] ^ s[0];
        s[4] = s[0];
        if (up) s[5] = d[3];
        return {r, s};
    endfunction : shx
    task automatic t_shift();
        logic [7:0] v[3] = '{8'h81, 8'h08, 8'h40};
        for (int i = 1; i <= 5; i++) begin
            foreach (v[j]) begin
                go(5'(i), v[j], 3'h0, 0);
                {m[7:0], sr} = shx(5'(i), v[j], sr);
                chk({8'h00, m[7:0]}, {8'h00, o.result});
                chk({8'h00, sr}, {8'h00, o.status_flags_reg});
                chk(16'h1, 16'(n));
            end
        end
        go(5'h06, 8'ha5, 3'h0, 0);
        chk({8'h5a, sr}, {o.result, o.status_flags_reg});
        $display("shift test done");
    endtask : t_shift
    task automatic t_flags();
        for (int b = 0; b < 8; b++) begin
            go(5'h0b, 8'h00, 3'(b), 0);
            sr[b] = 1'b1;
            chk({8'h01, sr}, {16'(n)} << 8 | o.status_flags_reg);
            go(5'h0c, 8'h00, 3'(b), 0);
            sr[b] = 1'b0;
            chk({8'h01, sr}, {16'(n)} << 8 | o.status_flags_reg);
        end
        $display("flag test done");
    endtask : t_flags
    task automatic t_bits();
        go(5'h09, 8'h08, 3'h3, 0);
        sr[6] = 1'b1;
        chk({8'h01, sr}, {8'(n), o.status_flags_reg});
        go(5'h0a, 8'h00, 3'h5, 0);
        chk({8'h20, sr}, {o.result, o.status_flags_reg});
        go(5'h09, 8'hfe, 3'h0, 0);
        sr[6] = 1'b0;
        chk({8'h01, sr}, {8'(n), o.status_flags_reg});
        go(5'h0a, 8'hff, 3'h0, 0);
        chk({8'hfe, sr}, {o.result, o.status_flags_reg});
        $display("bit test done");
    endtask : t_bits
    task automatic t_io();
        req.io_rdata = 8'h00;
        go(5'h07, 8'h00, 3'h7, 0);
        chk({8'h80, sr}, {o.io_wdata, o.status_flags_reg});
        chk(16'h0201, {8'(n), 7'h00, o.io_we});
        req.io_rdata = 8'hff;
        go(5'h08, 8'h00, 3'h0, 0);
        chk({8'hfe, sr}, {o.io_wdata, o.status_flags_reg});
        chk(16'h0201, {8'(n), 7'h00, o.io_we});
        for (int k = 13; k <= 15; k++) begin
            go(5'(k), 8'h00, 3'h0, 0);
            chk({5'h00, 3'(1 << (15 - k)), sr},
                {5'h00, o.debug_break, o.sleep_req, o.wdog_restart, o.status_flags_reg});
            chk(16'h1, 16'(n));
        end
        $display("io and control test done");
    endtask : t_io
    task automatic t_mem();
        req.base_cycles = 2'h2;
        req.mem_addr = 8'h50;
        go(5'h11, 8'h00, 3'h0, 0);
        m = n;
        req.mem_addr = 8'h10;
        go(5'h11, 8'h00, 3'h0, 0);
        chk(16'(m + 1), 16'(n));
        req.mem_addr = 8'h80;
        go(5'h12, 8'h00, 3'h0, 0);
        m = n;
        req.mem_nvm = 1'b1;
        go(5'h12, 8'h00, 3'h0, 0);
        chk(16'(m + 1), 16'(n));
        go(5'h12, 8'h00, 3'h0, 6);
        chk(16'h1, 16'(n > m + 1));
        req.mem_nvm = 1'b0;
        $display("memory timing test done");
    endtask : t_mem
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        t_shift();
        t_flags();
        t_bits();
        t_io();
        t_mem();
        test_done();
    end
    initial begin
        #100000;
        error_cnt++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
